/* rtl/pfs_sequencer.sv */
// main and fail-safe state machines of the power sequencer
`include "pfs_defs.svh"

module pfs_sequencer #(
    parameter int unsigned TOPO_CYC   = `PFS_TOPO_CYC,
    parameter int unsigned SOFT_CYC   = `PFS_SOFT_CYC,
    parameter int unsigned UV_CYC     = `PFS_UV_RETRY_CYC,
    parameter int unsigned SHORT_CYC  = `PFS_RST_SHORT_CYC,
    parameter int unsigned LONG_CYC   = `PFS_RST_LONG_CYC,
    parameter int unsigned INIT_CYC   = `PFS_INIT_WIN_CYC,
    parameter int unsigned RSTLOW_CYC = `PFS_RST_LOW_CYC
) (
    input  wire logic             i_mclk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_gate_above_thr,
    input  wire logic             i_select_to_pre,
    input  wire logic [1:0]       i_select_code,
    input  wire logic             i_pre_uv,
    input  wire logic             i_supply_low,
    input  wire logic             i_key,
    input  wire logic [2:0]       i_wake_src,
    input  wire logic [2:0]       i_wake_en,
    input  wire logic             i_logic_self_test_ok,
    input  wire logic             i_logic_self_test_done,
    input  wire logic             i_analog_self_test_ok,
    input  wire logic             i_analog_self_test_done,
    input  wire logic             i_wr_init_only,
    input  wire logic [1:0]       i_wr_init_data,
    input  wire logic             i_wr_init_finish,
    input  wire logic             i_wr_fs_cfg,
    input  wire logic             i_wr_long_delay,
    input  wire logic             i_wr_limit_hi,
    input  wire logic             i_wr_timer_dis,
    input  wire logic             i_sleep_cmd,
    input  wire logic             i_wd_good,
    input  wire logic             i_wd_bad,
    input  wire logic             i_wd_bad_limit,
    input  wire logic             i_ext_rst_req,
    input  wire logic             i_rst_fault,
    input  wire logic             i_fs_release,
    output logic                  o_gate_probe,
    output logic                  o_buck_boost,
    output logic                  o_pre_en,
    output logic                  o_pre_linear,
    output logic                  o_core_en,
    output logic                  o_aux_en,
    output logic                  o_ref_en,
    output logic                  o_can5v_en,
    output logic [1:0]            o_supply_sel,
    output logic [1:0]            o_init_cfg,
    output logic                  o_init_locked,
    output logic [2:0]            o_wake_rec,
    output logic [2:0]            o_rst_err_cnt,
    output logic                  o_normal,
    output logic                  o_mcu_reset_n,
    output logic                  o_failsafe_out_n
);
    import pfs_pkg::*;

    pfs_main_e                 m_reg, m_next;
    pfs_fs_e                   f_reg, f_next;
    logic [`PFS_CNT_W-1:0]     mt_reg, mt_next;
    logic [`PFS_CNT_W-1:0]     ft_reg, ft_next;
    logic [`PFS_CNT_W-1:0]     lt_reg, lt_next;
    logic                      bb_reg, bb_next;
    logic                      auxoff_reg, auxoff_next;
    logic [1:0]                sel_reg, sel_next;
    logic [1:0]                icfg_reg, icfg_next;
    logic                      lock_reg, lock_next;
    logic [2:0]                wrec_reg, wrec_next;
    logic                      long_reg, long_next;
    logic                      lim_reg, lim_next;
    logic                      tdis_reg, tdis_next;
    logic                      first_reg, first_next;
    logic [2:0]                cnt_reg, cnt_next;
    logic                      rstn_reg, rstn_next;
    logic                      fsn_reg, fsn_next;
    logic                      lt_on_reg, lt_on_next;
    logic                      key_s1_reg, key_s2_reg, key_d_reg;
    logic                      key_rise;
    logic                      fs_restart;
    logic                      wake;
    logic [2:0]                limit;
    logic                      regs_off;

    // key synchronizer
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            key_s1_reg <= 1'b0;
            key_s2_reg <= 1'b0;
            key_d_reg  <= 1'b0;
        end else begin
            key_s1_reg <= i_key;
            key_s2_reg <= key_s1_reg;
            key_d_reg  <= key_s2_reg;
        end
    end
    assign key_rise = key_s2_reg & ~key_d_reg;
    assign wake     = |(i_wake_src & i_wake_en);
    assign limit    = lim_reg ? `PFS_ERR_LIM_HI : `PFS_ERR_LIM_LO;
    assign regs_off = (f_next == PFS_F_DEEP);

    // main machine
    always_comb begin
        m_next      = m_reg;
        mt_next     = mt_reg + 1'b1;
        bb_next     = bb_reg;
        auxoff_next = auxoff_reg;
        sel_next    = sel_reg;
        icfg_next   = icfg_reg;
        lock_next   = lock_reg;
        wrec_next   = wrec_reg;
        fs_restart  = 1'b0;
        if (i_wr_init_only && m_reg == PFS_M_INIT && !lock_reg) begin
            icfg_next = i_wr_init_data;
        end
        case (m_reg)
            PFS_M_TOPO: begin
                if (i_gate_above_thr) begin
                    bb_next = 1'b1;
                    m_next  = PFS_M_PRE;
                    mt_next = '0;
                end else if (mt_reg >= TOPO_CYC - 1) begin
                    bb_next = 1'b0;
                    m_next  = PFS_M_PRE;
                    mt_next = '0;
                end
            end
            PFS_M_PRE: begin
                if (mt_reg >= SOFT_CYC - 1) begin
                    m_next  = PFS_M_SEL;
                    mt_next = '0;
                end
            end
            PFS_M_SEL: begin
                auxoff_next = i_select_to_pre;
                sel_next    = i_select_code;
                m_next      = PFS_M_REGON;
                mt_next     = '0;
            end
            PFS_M_REGON: begin
                if (mt_reg >= SOFT_CYC - 1) begin
                    m_next = PFS_M_WAITR;
                end
            end
            PFS_M_WAITR: begin
                if (rstn_reg) begin
                    m_next    = PFS_M_INIT;
                    lock_next = 1'b0;
                end
            end
            PFS_M_INIT: begin
                if (i_pre_uv) begin
                    m_next  = PFS_M_UV;
                    mt_next = '0;
                end else if (i_wr_init_finish) begin
                    lock_next = 1'b1;
                    m_next    = PFS_M_NORM;
                end
            end
            PFS_M_NORM: begin
                if (i_pre_uv) begin
                    m_next  = PFS_M_UV;
                    mt_next = '0;
                end else if (i_sleep_cmd && cnt_reg == 3'h0) begin
                    m_next = PFS_M_SLEEP;
                end
            end
            PFS_M_SLEEP: begin
                if (wake) begin
                    wrec_next  = i_wake_src & i_wake_en;
                    m_next     = PFS_M_TOPO;
                    mt_next    = '0;
                    fs_restart = 1'b1;
                end
            end
            PFS_M_UV: begin
                if (mt_reg >= UV_CYC - 1) begin
                    m_next     = PFS_M_TOPO;
                    mt_next    = '0;
                    fs_restart = 1'b1;
                end
            end
            PFS_M_DEEP: begin
                if (key_rise) begin
                    m_next     = PFS_M_TOPO;
                    mt_next    = '0;
                    fs_restart = 1'b1;
                end
            end
            default: m_next = PFS_M_TOPO;
        endcase
        if (f_reg == PFS_F_DEEP && !key_s2_reg && m_reg != PFS_M_DEEP) begin
            m_next = PFS_M_DEEP;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            m_reg      <= PFS_M_TOPO;
            mt_reg     <= '0;
            bb_reg     <= 1'b0;
            auxoff_reg <= 1'b0;
            sel_reg    <= 2'h0;
            icfg_reg   <= 2'h0;
            lock_reg   <= 1'b0;
            wrec_reg   <= 3'h0;
        end else begin
            m_reg      <= m_next;
            mt_reg     <= mt_next;
            bb_reg     <= bb_next;
            auxoff_reg <= auxoff_next;
            sel_reg    <= sel_next;
            icfg_reg   <= icfg_next;
            lock_reg   <= lock_next;
            wrec_reg   <= wrec_next;
        end
    end

    // fail-safe machine
    always_comb begin
        f_next     = f_reg;
        ft_next    = ft_reg + 1'b1;
        long_next  = long_reg;
        lim_next   = lim_reg;
        tdis_next  = tdis_reg;
        first_next = first_reg;
        cnt_next   = cnt_reg;
        rstn_next  = rstn_reg;
        fsn_next   = fsn_reg;
        lt_on_next = lt_on_reg;
        lt_next    = lt_on_reg ? lt_reg + 1'b1 : '0;
        if (i_fs_release && f_reg == PFS_F_RUN) begin
            fsn_next = 1'b1;
        end
        case (f_reg)
            PFS_F_LOGIC_SELF_TEST: begin
                rstn_next = 1'b0;
                // logic test; failure waits for timer
                if (i_logic_self_test_done && i_logic_self_test_ok) begin
                    f_next = PFS_F_ANALOG_SELF_TEST;
                end
            end
            PFS_F_ANALOG_SELF_TEST: begin
                if (i_analog_self_test_done && i_analog_self_test_ok && m_reg == PFS_M_WAITR) begin
                    f_next  = PFS_F_RSTDLY;
                    ft_next = '0;
                end
            end
            PFS_F_INIT: begin
                if (i_wr_fs_cfg) begin
                    long_next = i_wr_long_delay;
                    lim_next  = i_wr_limit_hi;
                    tdis_next = i_wr_timer_dis;
                end
                if (i_wd_good) begin
                    f_next = PFS_F_RUN;
                end else if (i_wd_bad || ft_reg >= INIT_CYC - 1 || i_rst_fault) begin
                    f_next     = PFS_F_RSTDLY;
                    ft_next    = '0;
                    rstn_next  = 1'b0;
                    cnt_next   = cnt_reg + 1'b1;
                    lt_on_next = ~tdis_reg;
                    lt_next    = '0;
                end
            end
            PFS_F_RUN: begin
                if (i_wd_bad_limit || i_ext_rst_req || i_rst_fault) begin
                    f_next     = PFS_F_RSTDLY;
                    ft_next    = '0;
                    rstn_next  = 1'b0;
                    cnt_next   = cnt_reg + 1'b1;
                    lt_on_next = ~tdis_reg;
                    lt_next    = '0;
                end
            end
            PFS_F_RSTDLY: begin
                if (ft_reg >= (first_reg ? LONG_CYC : (long_reg ? LONG_CYC : SHORT_CYC)) - 1
                    && !i_rst_fault && !i_ext_rst_req) begin
                    rstn_next  = 1'b1;
                    first_next = 1'b0;
                    lt_on_next = 1'b0;
                    f_next     = PFS_F_INIT;
                    ft_next    = '0;
                end
            end
            PFS_F_WDEEP: begin
                f_next = PFS_F_DEEP;
            end
            PFS_F_DEEP: begin
                rstn_next  = 1'b0;
                fsn_next   = 1'b0;
                lt_on_next = 1'b0;
            end
            default: f_next = PFS_F_LOGIC_SELF_TEST;
        endcase
        if (m_reg == PFS_M_SEL) begin
            lt_on_next = 1'b1;
        end
        if (f_reg != PFS_F_DEEP && f_reg != PFS_F_WDEEP &&
            (cnt_reg >= limit || (lt_on_reg && lt_reg >= RSTLOW_CYC - 1))) begin
            f_next = PFS_F_WDEEP;
        end
        if (fs_restart) begin
            f_next     = PFS_F_LOGIC_SELF_TEST;
            long_next  = 1'b0;
            lim_next   = 1'b0;
            tdis_next  = 1'b0;
            first_next = 1'b1;
            cnt_next   = 3'h0;
            rstn_next  = 1'b0;
            fsn_next   = 1'b0;
            lt_on_next = 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            f_reg     <= PFS_F_LOGIC_SELF_TEST;
            ft_reg    <= '0;
            lt_reg    <= '0;
            long_reg  <= 1'b0;
            lim_reg   <= 1'b0;
            tdis_reg  <= 1'b0;
            first_reg <= 1'b1;
            cnt_reg   <= 3'h0;
            rstn_reg  <= 1'b0;
            fsn_reg   <= 1'b0;
            lt_on_reg <= 1'b0;
        end else begin
            f_reg     <= f_next;
            ft_reg    <= ft_next;
            lt_reg    <= lt_next;
            long_reg  <= long_next;
            lim_reg   <= lim_next;
            tdis_reg  <= tdis_next;
            first_reg <= first_next;
            cnt_reg   <= cnt_next;
            rstn_reg  <= rstn_next;
            fsn_reg   <= fsn_next;
            lt_on_reg <= lt_on_next;
        end
    end

    // registered outputs
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_gate_probe     <= 1'b0;
            o_buck_boost     <= 1'b0;
            o_pre_en         <= 1'b0;
            o_pre_linear     <= 1'b0;
            o_core_en        <= 1'b0;
            o_aux_en         <= 1'b0;
            o_ref_en         <= 1'b0;
            o_can5v_en       <= 1'b0;
            o_supply_sel     <= 2'h0;
            o_init_cfg       <= 2'h0;
            o_init_locked    <= 1'b0;
            o_wake_rec       <= 3'h0;
            o_rst_err_cnt    <= 3'h0;
            o_normal         <= 1'b0;
            o_mcu_reset_n    <= 1'b0;
            o_failsafe_out_n <= 1'b0;
        end else begin
            o_gate_probe     <= (m_next == PFS_M_TOPO);
            o_buck_boost     <= bb_next;
            // regulators off in low-power-off and deep
            o_pre_en         <= !regs_off && (!(m_next inside {PFS_M_TOPO, PFS_M_SLEEP,
                                 PFS_M_UV, PFS_M_DEEP}) ||
                                 (m_next == PFS_M_SLEEP && i_supply_low));
            o_pre_linear     <= (m_next == PFS_M_SLEEP) && !bb_next;
            o_core_en        <= !regs_off && (m_next inside {PFS_M_REGON, PFS_M_WAITR,
                                 PFS_M_INIT, PFS_M_NORM});
            o_aux_en         <= !regs_off && !auxoff_next && (m_next inside {PFS_M_REGON,
                                 PFS_M_WAITR, PFS_M_INIT, PFS_M_NORM});
            o_ref_en         <= !regs_off && (m_next inside {PFS_M_REGON, PFS_M_WAITR,
                                 PFS_M_INIT, PFS_M_NORM});
            o_can5v_en       <= !regs_off && (m_next inside {PFS_M_REGON, PFS_M_WAITR,
                                 PFS_M_INIT, PFS_M_NORM});
            o_supply_sel     <= sel_next;
            o_init_cfg       <= icfg_next;
            o_init_locked    <= lock_next;
            o_wake_rec       <= wrec_next;
            o_rst_err_cnt    <= cnt_next;
            o_normal         <= (m_next == PFS_M_NORM);
            o_mcu_reset_n    <= rstn_next;
            o_failsafe_out_n <= fsn_next;
        end
    end

    // checks
    property p_deep_regs_off;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (m_reg == PFS_M_DEEP) |=> !o_core_en && !o_ref_en;
    endproperty
    a_deep_regs_off: assert property (p_deep_regs_off) else $error("regs on in deep");
    property p_lock;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (m_reg == PFS_M_INIT && i_wr_init_finish && !i_pre_uv) |=> o_normal && o_init_locked;
    endproperty
    a_lock: assert property (p_lock) else $error("init finish not honoured");
    property p_ignore;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (lock_reg && !fs_restart) |=> $stable(icfg_reg) || m_reg == PFS_M_INIT;
    endproperty
    a_ignore: assert property (p_ignore) else $error("locked cfg changed");
    property p_sleep_zero;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (m_reg != PFS_M_SLEEP && m_next == PFS_M_SLEEP) |-> cnt_reg == 3'h0 && m_reg == PFS_M_NORM;
    endproperty
    a_sleep_zero: assert property (p_sleep_zero) else $error("bad sleep entry");
    property p_limit;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (cnt_reg >= limit && f_reg != PFS_F_DEEP && f_reg != PFS_F_WDEEP && !fs_restart)
        |=> f_reg == PFS_F_WDEEP;
    endproperty
    a_limit: assert property (p_limit) else $error("limit ignored");
    property p_fs_deep_off;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (f_reg == PFS_F_DEEP) |-> !o_pre_en && !o_core_en && !o_ref_en && !o_can5v_en;
    endproperty
    a_fs_deep_off: assert property (p_fs_deep_off) else $error("regs on in fs deep");
    property p_key;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (m_reg == PFS_M_DEEP && key_rise) |=> m_reg == PFS_M_TOPO;
    endproperty
    a_key: assert property (p_key) else $error("key wake missed");
    property p_wake_clear;
        @(posedge i_mclk) disable iff (i_sys_rst)
        fs_restart |=> f_reg == PFS_F_LOGIC_SELF_TEST && !lim_reg && cnt_reg == 3'h0;
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("fs cfg kept");
    property p_rst_hold;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (f_reg == PFS_F_LOGIC_SELF_TEST) |=> ##1 !o_mcu_reset_n;
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("reset released in test");
    c_normal: cover property (@(posedge i_mclk) m_reg == PFS_M_NORM);
    c_sleep:  cover property (@(posedge i_mclk) m_reg == PFS_M_SLEEP ##1 m_reg == PFS_M_TOPO);
    c_deep:   cover property (@(posedge i_mclk) f_reg == PFS_F_DEEP);
endmodule

/* shared/pfs_defs.svh */
// timing and field constants for the power fail-safe sequencer
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH
`define PFS_CLK_MHZ        200
`define PFS_TOPO_TMO_US    120
`define PFS_TOPO_CYC       (`PFS_TOPO_TMO_US * `PFS_CLK_MHZ)
`define PFS_UV_RETRY_US    1000
`define PFS_UV_RETRY_CYC   (`PFS_UV_RETRY_US * `PFS_CLK_MHZ)
`define PFS_RST_SHORT_US   1000
`define PFS_RST_LONG_US    10000
`define PFS_RST_SHORT_CYC  (`PFS_RST_SHORT_US * `PFS_CLK_MHZ)
`define PFS_RST_LONG_CYC   (`PFS_RST_LONG_US * `PFS_CLK_MHZ)
`define PFS_INIT_WIN_MS    256
`define PFS_INIT_WIN_CYC   (`PFS_INIT_WIN_MS * 1000 * `PFS_CLK_MHZ)
`define PFS_RST_LOW_S      8
`define PFS_RST_LOW_CYC    (`PFS_RST_LOW_S * 1000000 * `PFS_CLK_MHZ)
`define PFS_SOFT_CYC       2000
`define PFS_ERR_LIM_LO     3'h2
`define PFS_ERR_LIM_HI     3'h6
`define PFS_CNT_W          32
`endif

/* shared/pfs_pkg.sv */
// state types for the power fail-safe sequencer
package pfs_pkg;
    typedef enum logic [9:0] {
        PFS_M_TOPO   = 10'h001,
        PFS_M_PRE    = 10'h002,
        PFS_M_SEL    = 10'h004,
        PFS_M_REGON  = 10'h008,
        PFS_M_WAITR  = 10'h010,
        PFS_M_INIT   = 10'h020,
        PFS_M_NORM   = 10'h040,
        PFS_M_SLEEP  = 10'h080,
        PFS_M_UV     = 10'h100,
        PFS_M_DEEP   = 10'h200
    } pfs_main_e;
    typedef enum logic [6:0] {
        PFS_F_LOGIC_SELF_TEST  = 7'h01,
        PFS_F_ANALOG_SELF_TEST  = 7'h02,
        PFS_F_INIT   = 7'h04,
        PFS_F_RUN    = 7'h08,
        PFS_F_RSTDLY = 7'h10,
        PFS_F_WDEEP  = 7'h20,
        PFS_F_DEEP   = 7'h40
    } pfs_fs_e;
endpackage

/* tb/pfs_mcu_model.sv */
// controller model: fail-safe config, init finish, first refresh, release
module pfs_mcu_model (
    input  wire logic i_mclk,
    input  wire logic i_reset_n,
    output logic      o_fs_cfg,
    output logic      o_long,
    output logic      o_limit_hi,
    output logic      o_timer_dis,
    output logic      o_init_finish,
    output logic      o_wd_good,
    output logic      o_fs_release
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic pulse(ref logic s);
        @(negedge i_mclk) s = 1'b1;
        @(negedge i_mclk) s = 1'b0;
    endtask
    initial begin
        {o_fs_cfg, o_long, o_limit_hi, o_timer_dis} = 4'h0;
        {o_init_finish, o_wd_good, o_fs_release} = 3'h0;
        forever begin
            @(posedge i_reset_n);
            repeat (4) @(negedge i_mclk);
            {o_long, o_limit_hi} = 2'h3;
            pulse(o_fs_cfg);
            // init finish write ends main init
            pulse(o_init_finish);
            // first refresh inside the open window
            pulse(o_wd_good);
            pulse(o_fs_release);
        end
    end
endmodule

/* tb/test_pfs_sequencer.sv */
// self-checking bench of the power fail-safe sequencer
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("CHECK FAILED %0t got %b exp %b", $time, a, b); end end
module test_pfs_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk = 0, i_sys_rst = 1, i_gate_above_thr = 0, i_select_to_pre = 0, i_pre_uv = 0;
    logic i_supply_low = 0, i_key = 1, i_logic_self_test_ok = 1, i_logic_self_test_done = 0, i_analog_self_test_ok = 1;
    logic i_analog_self_test_done = 0, i_wr_init_only = 0, i_sleep_cmd = 0, i_wd_bad = 0;
    logic i_wd_bad_limit = 0, i_ext_rst_req = 0, i_rst_fault = 0;
    logic [1:0] i_select_code = 0, i_wr_init_data = 0, d, sc;
    logic [2:0] i_wake_src = 0, i_wake_en = 0, o_wake_rec, ws;
    logic i_wr_init_finish, i_wr_fs_cfg, i_wr_long_delay, i_wr_limit_hi, i_wr_timer_dis;
    logic i_wd_good, i_fs_release, o_gate_probe, o_buck_boost, o_pre_en, o_core_en, o_aux_en;
    logic o_ref_en, o_can5v_en, o_init_locked, o_normal, o_mcu_reset_n, o_failsafe_out_n;
    logic [1:0] o_init_cfg, o_supply_sel;
    logic [2:0] o_rst_err_cnt;
    logic o_pre_linear;
    logic [21:0] snap;
    logic [43:0] q[$];
    int err_count = 0, tests_run = 0;
    event chk_ev;
    assign snap = {o_pre_linear, o_supply_sel, o_rst_err_cnt, o_wake_rec, o_init_cfg,
                   o_gate_probe, o_buck_boost, o_pre_en, o_core_en, o_aux_en, o_ref_en,
                   o_can5v_en, o_normal, o_init_locked, o_mcu_reset_n, o_failsafe_out_n};
    pfs_sequencer #(.TOPO_CYC(20), .SOFT_CYC(10), .UV_CYC(20), .SHORT_CYC(10), .LONG_CYC(30),
        .INIT_CYC(200), .RSTLOW_CYC(400)) u_pfs_sequencer (.i_mclk, .i_sys_rst,
        .i_gate_above_thr, .i_select_to_pre, .i_select_code, .i_pre_uv, .i_supply_low, .i_key,
        .i_wake_src, .i_wake_en, .i_logic_self_test_ok, .i_logic_self_test_done, .i_analog_self_test_ok, .i_analog_self_test_done,
        .i_wr_init_only, .i_wr_init_data, .i_wr_init_finish, .i_wr_fs_cfg, .i_wr_long_delay,
        .i_wr_limit_hi, .i_wr_timer_dis, .i_sleep_cmd, .i_wd_good, .i_wd_bad, .i_wd_bad_limit,
        .i_ext_rst_req, .i_rst_fault, .i_fs_release, .o_gate_probe, .o_buck_boost, .o_pre_en,
        .o_pre_linear, .o_core_en, .o_aux_en, .o_ref_en, .o_can5v_en, .o_supply_sel,
        .o_init_cfg, .o_init_locked, .o_wake_rec, .o_rst_err_cnt, .o_normal, .o_mcu_reset_n,
        .o_failsafe_out_n);
    pfs_mcu_model u_pfs_mcu_model (.i_mclk, .i_reset_n(o_mcu_reset_n), .o_fs_cfg(i_wr_fs_cfg),
        .o_long(i_wr_long_delay), .o_limit_hi(i_wr_limit_hi), .o_timer_dis(i_wr_timer_dis),
        .o_init_finish(i_wr_init_finish), .o_wd_good(i_wd_good), .o_fs_release(i_fs_release));
    initial begin
        forever #2.5 i_mclk = ~i_mclk;
    end
    // each queued note, oldest first, against the settled outputs
    always @(chk_ev) begin
        while (q.size() != 0) begin
            `CHK(snap & q[0][43:22], q[0][21:0])
            void'(q.pop_front());
        end
    end
    task automatic note(input logic [21:0] m, input logic [21:0] e);
        q.push_back({m, e});
        -> chk_ev;
    endtask
    task automatic wt(input int b, input logic v, input int n);
        for (int k = 0; k < n && snap[b] !== v; k++) @(negedge i_mclk);
        if (snap[b] !== v) begin
            err_count++;
            $display("CHECK FAILED %0t no change on bit %0d", $time, b);
        end
    endtask
    task automatic results();
        if (err_count == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #100us err_count++;
        results();
    end
    initial begin
        void'($urandom(32'haaa9));
        d = 2'($urandom);
        sc = 2'($urandom);
        ws = 3'h1 << ($urandom % 3);
        repeat (10) @(negedge i_mclk);
        {i_sys_rst, i_logic_self_test_done, i_analog_self_test_done, i_select_code} = {3'h3, sc};
        wt(10, 1, 5);
        note(22'h000403, 22'h000400);
        i_gate_above_thr = 1;
        wt(8, 1, 30);
        note(22'h000300, 22'h000300);
        wt(6, 1, 60);
        note(22'h1800f0, {1'b0, sc, 19'h0000f0});
        wt(1, 1, 300);
        // main init is entered one edge after reset release
        @(negedge i_mclk) {i_wr_init_only, i_wr_init_data} = {1'b1, d};
        @(negedge i_mclk) i_wr_init_only = 0;
        wt(3, 1, 60);
        note(22'h00180c, {9'h0, d, 11'h00c});
        {i_wr_init_only, i_wr_init_data} = {1'b1, ~d};
        @(negedge i_mclk) i_wr_init_only = 0;
        wt(0, 1, 30);
        note(22'h001800, {9'h0, d, 11'h0});
        @(negedge i_mclk) i_sleep_cmd = 1;
        @(negedge i_mclk) i_sleep_cmd = 0;
        wt(7, 0, 10);
        note(22'h0701f8, 22'h0);
        i_supply_low = 1;
        wt(8, 1, 10);
        note(22'h200300, 22'h000300);
        {i_supply_low, i_gate_above_thr, i_select_to_pre} = 3'h1;
        {i_wake_en, i_wake_src} = {3'h7, ws};
        @(negedge i_mclk) i_wake_src = 0;
        wt(10, 1, 10);
        note(22'h07e403, {6'h0, ws, 13'h0400});
        wt(8, 1, 30);
        note(22'h000200, 22'h0);
        wt(7, 1, 60);
        note(22'h0000f0, 22'h0000b0);
        wt(3, 1, 400);
        i_pre_uv = 1;
        wt(8, 0, 10);
        note(22'h000188, 22'h0);
        i_pre_uv = 0;
        wt(8, 1, 40);
        note(22'h000100, 22'h000100);
        // watchdog running, then external reset request
        wt(3, 1, 400);
        wt(0, 1, 40);
        i_ext_rst_req = 1;
        wt(1, 0, 5);
        note(22'h070002, 22'h010000);
        // fault held: reset never released, low timer reaches deep
        {i_ext_rst_req, i_rst_fault} = 2'h1;
        wt(0, 0, 420);
        note(22'h0001f3, 22'h0);
        {i_rst_fault, i_key} = 2'h0;
        repeat (4) @(negedge i_mclk);
        i_key = 1;
        wt(10, 1, 10);
        note(22'h070403, 22'h000400);
        results();
    end
endmodule
